// [logic/fsp_pkg.sv]
// Package for the flash status and protection block.
// Assumes a 200 MHz system clock; serial pins are sampled by that clock.
package fsp_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLOCK_MHZ = 200;
    localparam int STATUS_WRITE_NS = 1000;
    localparam int STATUS_WRITE_CYC = (STATUS_WRITE_NS * CLOCK_MHZ + 999) / 1000;
    localparam int TIMER_W = 10;

    // ------------------------------------------------------------------
    // Status register fields and reset values
    // ------------------------------------------------------------------
    localparam int STAT_FREEZE = 7;
    localparam int STAT_BP_MSB = 6;
    localparam int STAT_TOP_BOTTOM = 5;
    localparam int STAT_BP_HI = 4;
    localparam int STAT_BP_LO = 2;
    localparam int STAT_WEL = 1;
    localparam int STAT_WIP = 0;
    localparam logic FREEZE_RESET = 1'h0;
    localparam logic TOP_BOTTOM_RESET = 1'h0;
    localparam logic [3:0] BP_RESET = 4'h0;
    localparam logic WEL_RESET = 1'h0;

    // ------------------------------------------------------------------
    // Address space layout
    // ------------------------------------------------------------------
    localparam int ADDR_W = 26;
    localparam int SECTOR_SHIFT = 16;
    localparam int SUB32_SHIFT = 15;
    localparam int SUB4_SHIFT = 12;
    localparam int SECTOR_W = ADDR_W - SECTOR_SHIFT;
    localparam int SUB32_W = ADDR_W - SUB32_SHIFT;
    localparam int SUB4_W = ADDR_W - SUB4_SHIFT;
    localparam logic [3:0] BP_ALL = 4'hb;

    // ------------------------------------------------------------------
    // Serial frame sizes and command codes (codes are plain defaults)
    // ------------------------------------------------------------------
    localparam logic [5:0] CMD_BITS = 6'h08;
    localparam logic [5:0] ADDR_BITS = 6'h20;
    localparam logic [5:0] DATA_BITS = 6'h08;
    localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
    localparam logic [7:0] OP_PROGRAM = 8'h02;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_READ_STATUS = 8'h05;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_ERASE_4K = 8'h20;
    localparam logic [7:0] OP_ERASE_32K = 8'h52;
    localparam logic [7:0] OP_ERASE_ALL = 8'hc7;
    localparam logic [7:0] OP_ERASE_64K = 8'hd8;

    // Array operation kinds handed to the array controller.
    localparam logic [2:0] KIND_PROGRAM = 3'h1;
    localparam logic [2:0] KIND_ERASE_4K = 3'h2;
    localparam logic [2:0] KIND_ERASE_32K = 3'h3;
    localparam logic [2:0] KIND_ERASE_64K = 3'h4;
    localparam logic [2:0] KIND_ERASE_ALL = 3'h5;

    typedef enum logic [1:0] {PH_CMD, PH_ADDR, PH_DATA, PH_READ} fsp_phase_e;
    typedef enum logic [1:0] {BZ_IDLE, BZ_STATUS, BZ_ARRAY} fsp_busy_e;

endpackage : fsp_pkg

// [logic/fsp_region_decode.sv]
// Address decoder and block-protect check for the 512Mb array.
// Assumes a byte address below 0x4000000 and settled protect bits.
`timescale 1ns/100ps
module fsp_region_decode
    import fsp_pkg::*;
(
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [3:0] bp_i,
    input wire logic top_bottom_i,
    output logic [SECTOR_W-1:0] sector_o,
    output logic [SUB32_W-1:0] sub32_o,
    output logic [SUB4_W-1:0] sub4_o,
    output logic protected_o
);

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    logic [SECTOR_W:0] size;

    always_comb begin
        sector_o = addr_i[ADDR_W-1:SECTOR_SHIFT]; // RQ12
        sub32_o = addr_i[ADDR_W-1:SUB32_SHIFT]; // RQ12
        sub4_o = addr_i[ADDR_W-1:SUB4_SHIFT]; // RQ12
        // The region doubles with each step and covers everything from 11 up.
        if (bp_i == 4'h0) begin
            size = '0;
        end else if (bp_i >= BP_ALL) begin
            size = {1'b1, {SECTOR_W{1'b0}}};
        end else begin
            size = (SECTOR_W+1)'(1) << (bp_i - 4'h1); // RQ13
        end
        if (top_bottom_i) begin
            protected_o = {1'b0, sector_o} < size; // RQ13
        end else begin
            protected_o = {1'b0, sector_o} >=
                ({1'b1, {SECTOR_W{1'b0}}} - size); // RQ13
        end
        if (bp_i == 4'h0) begin
            protected_o = 1'b0;
        end
    end

endmodule : fsp_region_decode

// [logic/fsp_status_reg.sv]
// Status register, write protection and serial command front end.
// Assumes serial pins from another domain and an array controller
// on clock_i that pulses done when a program or erase ends.
//
// Notes on behaviour
// RQ1 - Read-status command returns the register; write-status command stores it.
// RQ2 - Freeze bit set with write-protect low makes status writes ignored.
// RQ3 - Hardware protection ends only when write-protect is driven high.
// RQ4 - Freeze bit sits at bit 7, zero after reset enables writes.
// RQ5 - Top/bottom select at bit 5; zero anchors region at the top.
// RQ6 - Block-protect bits at 6 and 4:2 refuse program/erase in region.
// RQ7 - Write-enable latch at bit 1, cleared at power-up.
// RQ8 - Writes, programs and erases run only while the latch is set.
// RQ9 - Bit 0 shows busy during status write, program or erase cycles.
// RQ10 - Whole-array erase runs only when all protect bits are zero.
// RQ11 - Status bit 0 is always the inverse of the ready flag.
// RQ12 - Address decodes into 64KB, 32KB and 4KB aligned units.
// RQ13 - Protected size is a power of two of sectors, top or bottom.
// RQ14 - Latch clears when the busy cycle finishes.
`timescale 1ns/100ps
module fsp_status_reg
    import fsp_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic dq0_i,
    input wire logic wp_n_i,
    input wire logic array_done_i,
    output logic dq1_o,
    output logic dq1_oe_o,
    output logic [7:0] status_o,
    output logic flag_ready_o,
    output logic array_start_o,
    output logic [2:0] array_kind_o,
    output logic [ADDR_W-1:0] array_addr_o,
    output logic [SECTOR_W-1:0] op_sector_o,
    output logic [SUB32_W-1:0] op_sub32_o,
    output logic [SUB4_W-1:0] op_sub4_o,
    output logic protect_error_o
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Three stages; a level is accepted only once stages two and three agree,
    // which filters a single-sample glitch on the serial lines.
    logic [3:0] s1, s2, s3, filt, next_filt;
    logic sclk_rise, sclk_fall, cs_rise, cs_fall;

    always_comb begin
        next_filt = filt;
        for (int i = 0; i < 4; i++) begin
            if (s2[i] == s3[i]) begin
                next_filt[i] = s3[i];
            end
        end
        sclk_rise = next_filt[0] & ~filt[0];
        sclk_fall = ~next_filt[0] & filt[0];
        cs_rise = next_filt[1] & ~filt[1];
        cs_fall = ~next_filt[1] & filt[1];
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            s1 <= 4'h2;
            s2 <= 4'h2;
            s3 <= 4'h2;
            filt <= 4'h2;
        end else begin
            s1 <= {wp_n_i, dq0_i, cs_n_i, sclk_i};
            s2 <= s1;
            s3 <= s2;
            filt <= next_filt;
        end
    end

    wire logic frame_on = ~filt[1];
    wire logic mosi = filt[2];
    wire logic wp_high = filt[3];

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic freeze, next_freeze, top_bottom, next_top_bottom;
    logic wel, next_wel;
    logic [3:0] bp, next_bp;
    fsp_busy_e busy_st, next_busy_st;
    logic [TIMER_W-1:0] timer, next_timer;
    logic busy;

    assign busy = busy_st != BZ_IDLE;
    always_comb begin
        status_o = {freeze, bp[3], top_bottom, bp[2:0], wel, busy}; // RQ9
        flag_ready_o = ~busy; // RQ11
    end

    // ------------------------------------------------------------------
    // Serial frame
    // ------------------------------------------------------------------
    fsp_phase_e phase, next_phase;
    logic [5:0] cnt, next_cnt;
    logic [7:0] opcode, next_opcode, out_sr, next_out_sr;
    logic [31:0] sr, next_sr;
    logic [2:0] ocnt, next_ocnt;
    logic next_dq1, next_oe;
    logic [ADDR_W-1:0] addr, next_addr;
    logic [7:0] wdata, next_wdata;
    logic frame_ok, next_frame_ok;

    always_comb begin
        next_phase = phase;
        next_cnt = cnt;
        next_opcode = opcode;
        next_sr = sr;
        next_out_sr = out_sr;
        next_ocnt = ocnt;
        next_dq1 = dq1_o;
        next_oe = dq1_oe_o;
        next_addr = addr;
        next_wdata = wdata;
        next_frame_ok = frame_ok;
        if (cs_fall) begin
            next_phase = PH_CMD;
            next_cnt = '0;
            next_frame_ok = 1'b0;
        end else if (frame_on && sclk_rise) begin
            next_sr = {sr[30:0], mosi};
            next_cnt = cnt + 6'h01;
            unique case (phase)
                PH_CMD: if (next_cnt == CMD_BITS) begin
                    next_opcode = next_sr[7:0];
                    next_cnt = '0;
                    next_frame_ok = 1'b1;
                    if (next_sr[7:0] == OP_READ_STATUS) begin
                        next_phase = PH_READ; // RQ1
                        next_ocnt = '0;
                    end else if (next_sr[7:0] == OP_WRITE_STATUS) begin
                        next_phase = PH_DATA;
                        next_frame_ok = 1'b0;
                    end else if (next_sr[7:0] == OP_PROGRAM ||
                                 next_sr[7:0] == OP_ERASE_4K ||
                                 next_sr[7:0] == OP_ERASE_32K ||
                                 next_sr[7:0] == OP_ERASE_64K) begin
                        next_phase = PH_ADDR;
                        next_frame_ok = 1'b0;
                    end else begin
                        next_phase = PH_DATA;
                    end
                end
                PH_ADDR: if (next_cnt == ADDR_BITS) begin
                    next_addr = next_sr[ADDR_W-1:0];
                    next_phase = PH_DATA;
                    next_frame_ok = 1'b1;
                end
                PH_DATA: if (next_cnt == DATA_BITS && !frame_ok) begin
                    next_wdata = next_sr[7:0];
                    next_frame_ok = 1'b1;
                end
                PH_READ: next_cnt = cnt;
            endcase
        end else if (frame_on && sclk_fall && phase == PH_READ) begin
            // The byte is reloaded each time so a poll sees busy drop live.
            next_oe = 1'b1;
            if (ocnt == 3'h0) begin
                next_dq1 = status_o[7]; // RQ1
                next_out_sr = {status_o[6:0], 1'b0};
            end else begin
                next_dq1 = out_sr[7];
                next_out_sr = {out_sr[6:0], 1'b0};
            end
            next_ocnt = ocnt + 3'h1;
        end
        if (!frame_on) begin
            next_oe = 1'b0;
            next_dq1 = 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            phase <= PH_CMD;
            cnt <= '0;
            opcode <= '0;
            sr <= '0;
            out_sr <= '0;
            ocnt <= '0;
            dq1_o <= 1'b0;
            dq1_oe_o <= 1'b0;
            addr <= '0;
            wdata <= '0;
            frame_ok <= 1'b0;
        end else begin
            phase <= next_phase;
            cnt <= next_cnt;
            opcode <= next_opcode;
            sr <= next_sr;
            out_sr <= next_out_sr;
            ocnt <= next_ocnt;
            dq1_o <= next_dq1;
            dq1_oe_o <= next_oe;
            addr <= next_addr;
            wdata <= next_wdata;
            frame_ok <= next_frame_ok;
        end
    end

    // ------------------------------------------------------------------
    // Protection check and command execution at frame end
    // ------------------------------------------------------------------
    logic [SECTOR_W-1:0] sector;
    logic [SUB32_W-1:0] sub32;
    logic [SUB4_W-1:0] sub4;
    logic region_prot;

    fsp_region_decode u_decode (
        .addr_i(addr),
        .bp_i(bp),
        .top_bottom_i(top_bottom),
        .sector_o(sector),
        .sub32_o(sub32),
        .sub4_o(sub4),
        .protected_o(region_prot)
    );

    logic next_start, next_perr;
    logic [2:0] next_kind;
    logic [ADDR_W-1:0] next_aaddr;
    logic [SECTOR_W-1:0] next_osec;
    logic [SUB32_W-1:0] next_osub32;
    logic [SUB4_W-1:0] next_osub4;
    logic hw_locked, do_cmd;

    always_comb begin
        next_freeze = freeze;
        next_top_bottom = top_bottom;
        next_bp = bp;
        next_wel = wel;
        next_busy_st = busy_st;
        next_timer = timer;
        next_start = 1'b0;
        next_perr = 1'b0;
        next_kind = array_kind_o;
        next_aaddr = array_addr_o;
        next_osec = op_sector_o;
        next_osub32 = op_sub32_o;
        next_osub4 = op_sub4_o;
        hw_locked = freeze & ~wp_high; // RQ2 RQ3 RQ4
        do_cmd = cs_rise & frame_ok & ~busy;
        if (do_cmd) begin
            unique case (opcode)
                OP_WRITE_ENABLE: next_wel = 1'b1; // RQ8
                OP_WRITE_DISABLE: next_wel = 1'b0;
                OP_WRITE_STATUS: if (wel && !hw_locked) begin // RQ2 RQ8
                    next_freeze = wdata[STAT_FREEZE]; // RQ4
                    next_top_bottom = wdata[STAT_TOP_BOTTOM]; // RQ5
                    next_bp = {wdata[STAT_BP_MSB],
                               wdata[STAT_BP_HI:STAT_BP_LO]}; // RQ6
                    next_busy_st = BZ_STATUS; // RQ9
                    next_timer = TIMER_W'(STATUS_WRITE_CYC);
                end
                OP_PROGRAM, OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K,
                OP_ERASE_ALL: if (wel) begin // RQ8
                    if (opcode == OP_ERASE_ALL ? bp != 4'h0 // RQ10
                                               : region_prot) begin // RQ6
                        next_perr = 1'b1;
                    end else begin
                        next_start = 1'b1;
                        next_busy_st = BZ_ARRAY; // RQ9
                        next_aaddr = addr;
                        next_osec = sector;
                        next_osub32 = sub32;
                        next_osub4 = sub4;
                        unique case (opcode)
                            OP_PROGRAM: next_kind = KIND_PROGRAM;
                            OP_ERASE_4K: next_kind = KIND_ERASE_4K;
                            OP_ERASE_32K: next_kind = KIND_ERASE_32K;
                            OP_ERASE_64K: next_kind = KIND_ERASE_64K;
                            default: next_kind = KIND_ERASE_ALL;
                        endcase
                    end
                end
                default: ;
            endcase
        end
        unique case (busy_st)
            BZ_IDLE: ;
            BZ_STATUS: begin
                next_timer = timer - TIMER_W'(1);
                if (timer == TIMER_W'(1)) begin
                    next_busy_st = BZ_IDLE;
                    next_wel = 1'b0; // RQ14
                end
            end
            BZ_ARRAY: if (array_done_i) begin
                next_busy_st = BZ_IDLE;
                next_wel = 1'b0; // RQ14
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            freeze <= FREEZE_RESET; // RQ4
            top_bottom <= TOP_BOTTOM_RESET; // RQ5
            bp <= BP_RESET;
            wel <= WEL_RESET; // RQ7
            busy_st <= BZ_IDLE;
            timer <= '0;
            array_start_o <= 1'b0;
            protect_error_o <= 1'b0;
            array_kind_o <= '0;
            array_addr_o <= '0;
            op_sector_o <= '0;
            op_sub32_o <= '0;
            op_sub4_o <= '0;
        end else begin
            freeze <= next_freeze;
            top_bottom <= next_top_bottom;
            bp <= next_bp;
            wel <= next_wel;
            busy_st <= next_busy_st;
            timer <= next_timer;
            array_start_o <= next_start;
            protect_error_o <= next_perr;
            array_kind_o <= next_kind;
            array_addr_o <= next_aaddr;
            op_sector_o <= next_osec;
            op_sub32_o <= next_osub32;
            op_sub4_o <= next_osub4;
        end
    end

endmodule : fsp_status_reg

// [verif/fsp_status_reg_chk.sv]
// Checker for the flash status block; it sees only the top ports.
// Assumes the host and the array controller keep their contracts.
`timescale 1ns/100ps
module fsp_status_reg_chk
    import fsp_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic cs_n_i,
    input wire logic wp_n_i,
    input wire logic array_done_i,
    input wire logic [7:0] status_o,
    input wire logic flag_ready_o,
    input wire logic dq1_oe_o,
    input wire logic array_start_o,
    input wire logic [2:0] array_kind_o,
    input wire logic [ADDR_W-1:0] array_addr_o,
    input wire logic [SECTOR_W-1:0] op_sector_o,
    input wire logic [SUB32_W-1:0] op_sub32_o,
    input wire logic [SUB4_W-1:0] op_sub4_o,
    input wire logic protect_error_o
);
    // ------------------------------------------------------------------
    // Settled pin levels
    // ------------------------------------------------------------------
    // Pins cross three flops, so a level is trusted only once it has held.
    logic [3:0] wp_low_cnt;
    logic [3:0] cs_high_cnt;
    logic [3:0] next_wp_low_cnt;
    logic [3:0] next_cs_high_cnt;
    always_comb begin
        next_wp_low_cnt = (wp_low_cnt == 4'hf) ? 4'hf : wp_low_cnt + 4'h1;
        next_cs_high_cnt = (cs_high_cnt == 4'hf) ? 4'hf : cs_high_cnt + 4'h1;
        if (wp_n_i) begin
            next_wp_low_cnt = 4'h0;
        end
        if (!cs_n_i) begin
            next_cs_high_cnt = 4'h0;
        end
    end
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            wp_low_cnt <= 4'h0;
            cs_high_cnt <= 4'h0;
        end else begin
            wp_low_cnt <= next_wp_low_cnt;
            cs_high_cnt <= next_cs_high_cnt;
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    chk_ready_flag: assert property (flag_ready_o == !status_o[0])
        else $error("ready flag disagrees with busy bit");
    chk_start_needs_wel: assert property (
        array_start_o |-> status_o[1:0] == 2'h3)
        else $error("array start without latch or busy");
    chk_done_clears: assert property (
        array_done_i && status_o[0] |=> status_o[1:0] == 2'h0)
        else $error("busy or latch left after array done");
    chk_status_busy_len: assert property (
        $rose(status_o[0]) && !array_start_o
        |-> ##195 status_o[0] ##[1:10] (status_o[1:0] == 2'h0))
        else $error("status write busy time wrong");
    chk_erase_all_bp: assert property (
        array_start_o && array_kind_o == KIND_ERASE_ALL
        |-> {status_o[6], status_o[4:2]} == 4'h0)
        else $error("whole erase started with protect bits set");
    chk_refuse_keeps: assert property (
        protect_error_o |-> !array_start_o && status_o[1:0] == 2'h2)
        else $error("protected op started or latch lost");
    chk_decode_units: assert property (
        array_start_o |-> op_sector_o == array_addr_o[ADDR_W-1:16]
        && op_sub32_o == array_addr_o[ADDR_W-1:15]
        && op_sub4_o == array_addr_o[ADDR_W-1:12])
        else $error("sector decode wrong");
    chk_freeze_holds: assert property (
        wp_low_cnt == 4'hf && status_o[7] |=> $stable(status_o[7:2]))
        else $error("frozen status bits changed");
    chk_idle_no_drive: assert property (cs_high_cnt == 4'hf |-> !dq1_oe_o)
        else $error("data out driven while deselected");
    chk_busy_refuses: assert property (
        status_o[0] && $past(status_o[0]) |-> !array_start_o && !protect_error_o)
        else $error("command accepted while busy");
endmodule : fsp_status_reg_chk

// [verif/fsp_host_model.sv]
// Serial host model: chip select, link clock and data out, mode 0.
// Assumes the bench clock is 5 ns; the link runs at 80 ns.
`timescale 1ns/100ps
module fsp_host_model
    import fsp_pkg::*;
(
    input wire logic clock_i,
    input wire logic dq1_i,
    output logic cs_n_o,
    output logic sclk_o,
    output logic dq0_o
);
    // ------------------------------------------------------------------
    // Frame engine
    // ------------------------------------------------------------------
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        dq0_o = 1'b0;
    end
    task automatic half();
        repeat (8) @(negedge clock_i);
    endtask : half
    // The link clock rests low between frames, and the data line shows the
    // inverse of its last bit so a stale value cannot be mistaken for data.
    task automatic xfer(input logic [39:0] v, input int n,
                        output logic [7:0] rx);
        rx = 8'h00;
        @(negedge clock_i);
        cs_n_o = 1'b0;
        for (int i = 0; i < n; i++) begin
            dq0_o = v[39-i];
            half();
            sclk_o = 1'b1;
            rx = {rx[6:0], dq1_i};
            half();
            sclk_o = 1'b0;
        end
        half();
        cs_n_o = 1'b1;
        dq0_o = ~dq0_o;
        half();
        half();
    endtask : xfer
    task automatic send_op(input logic [7:0] op);
        logic [7:0] rx;
        xfer({op, 32'h0}, 8, rx);
    endtask : send_op
    task automatic send_byte(input logic [7:0] op, input logic [7:0] b);
        logic [7:0] rx;
        xfer({op, b, 24'h0}, 16, rx);
    endtask : send_byte
    task automatic send_addr(input logic [7:0] op, input logic [31:0] a);
        logic [7:0] rx;
        xfer({op, a}, 40, rx);
    endtask : send_addr
    task automatic read_status(output logic [7:0] st);
        xfer({OP_READ_STATUS, 32'h0}, 16, st);
    endtask : read_status
endmodule : fsp_host_model

// [verif/fsp_status_reg_test.sv]
// Testbench for the flash status block, with a serial host model.
// Assumes the bench itself plays the array controller's done pulse.
`timescale 1ns/100ps
module fsp_status_reg_test import fsp_pkg::*;;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic wp_n_i = 1'b1;
    logic array_done_i = 1'b0;
    logic cs_n, sclk, dq0, dq1_o, dq1_oe_o, dq1_w, flag_ready_o;
    logic array_start_o, protect_error_o;
    logic [7:0] status_o;
    logic [2:0] array_kind_o;
    logic [ADDR_W-1:0] array_addr_o;
    logic [SECTOR_W-1:0] op_sector_o;
    logic [SUB32_W-1:0] op_sub32_o;
    logic [SUB4_W-1:0] op_sub4_o;
    int error_cnt = 0;
    int checks = 0;
    int cycles = 0;
    int starts = 0;
    int perrs = 0;
    // A released data line toggles, so a read never sees a stale bit.
    assign dq1_w = dq1_oe_o ? dq1_o : sclk;
    always #2.5 clock_i = ~clock_i;
    fsp_status_reg uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n),
        .sclk_i(sclk), .dq0_i(dq0), .wp_n_i(wp_n_i),
        .array_done_i(array_done_i), .dq1_o(dq1_o), .dq1_oe_o(dq1_oe_o),
        .status_o(status_o), .flag_ready_o(flag_ready_o),
        .array_start_o(array_start_o), .array_kind_o(array_kind_o),
        .array_addr_o(array_addr_o), .op_sector_o(op_sector_o),
        .op_sub32_o(op_sub32_o), .op_sub4_o(op_sub4_o),
        .protect_error_o(protect_error_o));
    fsp_host_model host (.clock_i(clock_i), .dq1_i(dq1_w), .cs_n_o(cs_n),
        .sclk_o(sclk), .dq0_o(dq0));
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic close_out();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out
    always @(posedge clock_i) begin
        cycles++;
        if (array_start_o === 1'b1) begin
            starts++;
        end
        if (protect_error_o === 1'b1) begin
            perrs++;
        end
        if (cycles == 60000) begin
            error_cnt++;
            close_out();
        end
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic wait_idle();
        int n;
        n = 0;
        while (status_o[0] !== 1'b0 && n < 400) begin
            @(negedge clock_i);
            n++;
        end
        cmp(n < 400, 1);
    endtask : wait_idle
    task automatic write_status(input logic [7:0] d, input logic go,
                                input logic [7:0] exp);
        host.send_op(OP_WRITE_ENABLE);
        host.send_byte(OP_WRITE_STATUS, d);
        cmp(status_o[0], go);
        wait_idle();
        cmp(status_o[7:2], exp[7:2]);
    endtask : write_status
    task automatic array_op(input logic [7:0] op, input logic [31:0] a,
                            input logic ok, input logic [2:0] k);
        int s;
        int p;
        s = starts;
        p = perrs;
        host.send_op(OP_WRITE_ENABLE);
        host.send_addr(op, a);
        cmp(starts - s, ok);
        cmp(perrs - p, !ok);
        cmp(status_o[1:0], ok ? 2'h3 : 2'h2);
        if (ok) begin
            cmp(array_kind_o, k);
            cmp(op_sector_o, a[25:16]);
            cmp(op_sub32_o, a[25:15]);
            cmp(op_sub4_o, a[25:12]);
            cmp(array_addr_o, a[25:0]);
            array_done_i = 1'b1;
            @(negedge clock_i);
            array_done_i = 1'b0;
            repeat (2) @(negedge clock_i);
            cmp(status_o[1:0], 2'h0);
        end
    endtask : array_op
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        logic [7:0] rd;
        cmp(status_o, 8'h00);
        cmp(flag_ready_o, 1'b1);
        host.read_status(rd);
        cmp(rd, 8'h00);
        host.send_byte(OP_WRITE_STATUS, 8'h9c);
        cmp(status_o, 8'h00);
        host.send_op(OP_WRITE_ENABLE);
        cmp(status_o[1], 1'b1);
        host.send_op(OP_WRITE_DISABLE);
        cmp(status_o[1], 1'b0);
    endtask : t_reset
    task automatic t_freeze();
        logic [7:0] rd;
        write_status(8'h9f, 1'b1, 8'h9c);
        host.read_status(rd);
        cmp(rd, 8'h9c);
        wp_n_i = 1'b0;
        write_status(8'h00, 1'b0, 8'h9c);
        array_op(OP_PROGRAM, 32'h03c0_0000, 1'b0, KIND_PROGRAM);
        array_op(OP_ERASE_ALL, 32'h0, 1'b0, KIND_ERASE_ALL);
        array_op(OP_PROGRAM, 32'h03bf_ffff, 1'b1, KIND_PROGRAM);
        wp_n_i = 1'b1;
        write_status(8'h60, 1'b1, 8'h60);
    endtask : t_freeze
    task automatic t_bottom();
        array_op(OP_ERASE_64K, 32'h007f_0000, 1'b0, KIND_ERASE_64K);
        array_op(OP_ERASE_64K, 32'h0080_0000, 1'b1, KIND_ERASE_64K);
    endtask : t_bottom
    task automatic t_kinds();
        logic [7:0] ops [4];
        logic [2:0] kinds [4];
        ops = '{OP_PROGRAM, OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K};
        kinds = '{KIND_PROGRAM, KIND_ERASE_4K, KIND_ERASE_32K, KIND_ERASE_64K};
        write_status(8'h00, 1'b1, 8'h00);
        for (int i = 0; i < 4; i++) begin
            array_op(ops[i], 32'h03ff_f000, 1'b1, kinds[i]);
        end
        array_op(OP_ERASE_ALL, 32'h03ff_f000, 1'b1, KIND_ERASE_ALL);
    endtask : t_kinds
    initial begin
        repeat (12) @(negedge clock_i);
        rst_n_i = 1'b1;
        repeat (4) @(negedge clock_i);
        t_reset();
        t_freeze();
        t_bottom();
        t_kinds();
        close_out();
    end
endmodule : fsp_status_reg_test
bind fsp_status_reg fsp_status_reg_chk chk (.clock_i(clock_i),
    .rst_n_i(rst_n_i), .cs_n_i(cs_n_i), .wp_n_i(wp_n_i),
    .array_done_i(array_done_i), .status_o(status_o),
    .flag_ready_o(flag_ready_o), .dq1_oe_o(dq1_oe_o),
    .array_start_o(array_start_o), .array_kind_o(array_kind_o),
    .array_addr_o(array_addr_o), .op_sector_o(op_sector_o),
    .op_sub32_o(op_sub32_o), .op_sub4_o(op_sub4_o),
    .protect_error_o(protect_error_o));
